/* File: rtl/cms_pkg.sv */
package cms_pkg;
  // message center geometry
  localparam int NUM_CTR   = 15;
  localparam int SHADOW_CTR = 14;           // center 15, counted from zero
  localparam int IDX_W     = 4;
  localparam int ID_W      = 29;
  localparam int DLC_W     = 4;
  localparam int DATA_W    = 64;

  // incoming frame word: {remote, dlc, id, data}
  localparam int FRM_DATA_LSB = 0;
  localparam int FRM_ID_LSB   = DATA_W;
  localparam int FRM_DLC_LSB  = DATA_W + ID_W;
  localparam int FRM_RTR_BIT  = DATA_W + ID_W + DLC_W;
  localparam int FRAME_W      = FRM_RTR_BIT + 1;

  // module control byte, autobaud position
  localparam int MCTRL_W           = 8;
  localparam int MCTRL_AUTOBAUD_BIT = 2;

  // error counters
  localparam int ERR_W = 9;
  localparam logic [ERR_W-1:0] ERR_LIMIT    = 9'h080;   // flag once above this
  localparam logic [ERR_W-1:0] ERR_MAX      = 9'h1ff;
  localparam logic [ERR_W-1:0] ERR_RST      = 9'h000;
  localparam logic [ERR_W-1:0] ERR_STEP_ONE = 9'h001;
  localparam logic [ERR_W-1:0] ERR_STEP_EIGHT = 9'h008;

  // reset values
  localparam logic [NUM_CTR-1:0] CTR_VEC_RST = 15'h0000;
  localparam logic               SWINIT_RST  = 1'h1;
  localparam logic               TX_IDLE     = 1'h1;    // recessive level

  // receive buffer depth
  localparam int BUF_DEPTH = 2;
endpackage

/* File: rtl/cms_frame_if.sv */
`timescale 1ns/1ps
interface cms_frame_if;
  import cms_pkg::*;
  logic               valid;
  logic               ready;
  logic [FRAME_W-1:0] frame;
  modport src (output valid, output frame, input  ready);
  modport snk (input  valid, input  frame, output ready);
endinterface

/* File: rtl/cms_rx_buf.sv */
`timescale 1ns/1ps
module cms_rx_buf
  import cms_pkg::*;
#(
  parameter int W     = FRAME_W,
  parameter int DEPTH = BUF_DEPTH
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  // filling side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // draining side
  cms_frame_if.src          out
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0]   cnt_q;
  logic [PW:0]   cnt_d;
  logic          room_q;
  logic          push;
  logic          pop;

  // ready is a flop so the pin never sees a combinational path
  assign push       = in_valid_i && room_q;
  assign pop        = out.valid && out.ready;
  assign in_ready_o = room_q;
  assign out.valid  = (cnt_q != '0);
  assign out.frame  = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= '0;
      room_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q  <= cnt_d;
      room_q <= (cnt_d != (PW + 1)'(DEPTH));
    end
  end
endmodule // cms_rx_buf

/* File: rtl/cms_store.sv */
// Function
// - overwrite on, shared value: lowest center keeps taking every frame
// - overwrite onto unread data in centers 1 to 14 replaces it and sets updated and overwrite flags
// - overwrite off, center 1 full: frame goes to next center, flag set
// - overwrite off, all full: frame dropped, overwrite flag untouched
// - once center 1 is cleared, it takes the next frame again
// - center 15 empty: frames go straight into its registers
// - center 15 occupied: frames go into the shadow buffer
// - center 15 emptied: unread shadow contents move in automatically
// - overwrite on, center 15 occupied: frame replaces shadow; flag if shadow unread
// - shadow empty: frame stored there, overwrite flag stays clear
// - center 15 overwrite flag reflects only shadow overwrites
// - overwrite off, center 15 and shadow full: frame discarded
// - autobaud bit 2 loops receive as pin AND own transmit
// - autobaud holds transmit pin recessive high
// - errors count up; above 128 the exceeded flag sets
// - soft reset stops bus, sets init hold, clears enable registers
// - each center has its own overwrite enable bit
// - overwrite off: unread or request-pending centers are not overwritten
`timescale 1ns/1ps
module cms_store
  import cms_pkg::*;
(
  // clock and reset
  input  wire logic                CLK_I,
  input  wire logic                RESET_N_I,
  // accepted frames from the protocol engine
  input  wire logic                FRAME_VALID_I,
  input  wire logic [FRAME_W-1:0]  FRAME_I,
  output logic                     FRAME_READY_O,
  output logic                     FRAME_LOST_O,
  // center configuration
  input  wire logic                CFG_WE_I,
  input  wire logic [IDX_W-1:0]    CFG_IDX_I,
  input  wire logic [ID_W-1:0]     CFG_ARB_I,
  input  wire logic                CFG_OWE_I,
  input  wire logic                CFG_RX_I,
  // receive and transmit enable registers
  input  wire logic                EN_WE_I,
  input  wire logic [NUM_CTR-1:0]  RX_EN_I,
  input  wire logic [NUM_CTR-1:0]  TX_EN_I,
  output logic [NUM_CTR-1:0]       RX_EN_O,
  output logic [NUM_CTR-1:0]       TX_EN_O,
  // flag clears from software, one bit per center
  input  wire logic [NUM_CTR-1:0]  CLR_DATA_UPDATED_FLAG_I,
  input  wire logic [NUM_CTR-1:0]  CLR_EXTERNAL_REQUEST_PENDING_I,
  input  wire logic [NUM_CTR-1:0]  CLR_ROW_I,
  // flags
  output logic [NUM_CTR-1:0]       DATA_UPDATED_FLAG_O,
  output logic [NUM_CTR-1:0]       EXTERNAL_REQUEST_PENDING_O,
  output logic [NUM_CTR-1:0]       ROW_O,
  output logic                     SHADOW_FULL_O,
  // center read port
  input  wire logic [IDX_W-1:0]    RD_IDX_I,
  output logic [ID_W-1:0]          RD_ARB_O,
  output logic [DLC_W-1:0]         RD_DLC_O,
  output logic [DATA_W-1:0]        RD_DATA_O,
  // module control and soft reset
  input  wire logic [MCTRL_W-1:0]  MODULE_CTRL_I,
  input  wire logic                SOFT_RESET_I,
  input  wire logic                SWINIT_CLR_I,
  output logic                     SWINIT_O,
  // error events from the protocol engine
  input  wire logic                REC_INC1_I,
  input  wire logic                REC_INC8_I,
  input  wire logic                TEC_INC8_I,
  output logic [ERR_W-1:0]         REC_O,
  output logic [ERR_W-1:0]         TEC_O,
  output logic                     ERROR_COUNT_EXCEEDED_FLAG_O,
  // bus pins and engine side
  input  wire logic                RX_PIN_I,
  input  wire logic                TX_INT_I,
  output logic                     TX_PIN_O,
  output logic                     RX_INT_O
);
  cms_frame_if buf_if ();

  // center state
  logic [ID_W-1:0]    arb_q   [NUM_CTR];
  logic [DLC_W-1:0]   dlc_q   [NUM_CTR];
  logic [DATA_W-1:0]  data_q  [NUM_CTR];
  logic [NUM_CTR-1:0] owe_q;
  logic [NUM_CTR-1:0] rxm_q;
  logic [NUM_CTR-1:0] data_updated_flag_q;
  logic [NUM_CTR-1:0] external_request_pending_q;
  logic [NUM_CTR-1:0] row_q;
  logic [NUM_CTR-1:0] rx_en_q;
  logic [NUM_CTR-1:0] tx_en_q;
  // shadow of center 15
  logic [FRAME_W-1:0] sh_frame_q;
  logic               sh_full_q;
  // control and errors
  logic               swinit_q;
  logic [ERR_W-1:0]   rec_q;
  logic [ERR_W-1:0]   tec_q;
  logic               error_count_exceeded_flag_q;
  logic               lost_q;
  logic               rx_s1_q;
  logic               rx_s2_q;
  logic               tx_q;
  logic               rx_int_q;
  logic [ID_W-1:0]    rd_arb_q;
  logic [DLC_W-1:0]   rd_dlc_q;
  logic [DATA_W-1:0]  rd_data_q;

  // selection terms
  logic [ID_W-1:0]    f_id;
  logic               f_rtr;
  logic [NUM_CTR-1:0] occ;
  logic [NUM_CTR-1:0] hit;
  logic [NUM_CTR-1:0] elig;
  logic [IDX_W-1:0]   tgt;
  logic               any_elig;
  logic               take;
  logic               to_shadow;
  logic               move_now;
  logic               autobaud;
  logic [NUM_CTR-1:0] set_dt;
  logic [NUM_CTR-1:0] set_ex;
  logic [NUM_CTR-1:0] set_row;

  // two-entry buffer so a stall of the store loses no frame
  cms_rx_buf #(
    .W     (FRAME_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i      (CLK_I),
    .reset_n_i  (RESET_N_I),
    .in_valid_i (FRAME_VALID_I),
    .in_data_i  (FRAME_I),
    .in_ready_o (FRAME_READY_O),
    .out        (buf_if.src)
  );

  assign f_id     = buf_if.frame[FRM_ID_LSB +: ID_W];
  assign f_rtr    = buf_if.frame[FRM_RTR_BIT];
  assign autobaud = MODULE_CTRL_I[MCTRL_AUTOBAUD_BIT];
  assign occ      = data_updated_flag_q | external_request_pending_q;

  // shadow moves in only when center 15 is empty; new frames wait that cycle
  assign move_now     = sh_full_q && !occ[SHADOW_CTR];
  assign buf_if.ready = !move_now;

  // eligibility of each center for the frame at the buffer head
  always_comb begin
    hit  = '0;
    elig = '0;
    for (int i = 0; i < NUM_CTR; i++) begin
      hit[i] = rx_en_q[i] && rxm_q[i] && (arb_q[i] == f_id);
      if (i == SHADOW_CTR) begin
        // occupied center 15 still takes frames while the shadow has room
        elig[i] = hit[i] && (!occ[i] || !sh_full_q || owe_q[i]);
      end else begin
        elig[i] = hit[i] && (!occ[i] || owe_q[i]);
      end
    end
  end

  // lowest numbered eligible center wins
  always_comb begin
    tgt      = '0;
    any_elig = 1'b0;
    for (int i = NUM_CTR - 1; i >= 0; i--) begin
      if (elig[i]) begin
        tgt      = IDX_W'(i);
        any_elig = 1'b1;
      end
    end
  end

  // frames are consumed even while held in init, but not stored
  assign take      = buf_if.valid && buf_if.ready && !swinit_q && any_elig;
  assign to_shadow = take && (tgt == IDX_W'(SHADOW_CTR)) && occ[SHADOW_CTR];

  // flag set terms per center
  always_comb begin
    set_dt  = '0;
    set_ex  = '0;
    set_row = '0;
    for (int i = 0; i < NUM_CTR; i++) begin
      if (take && tgt == IDX_W'(i) && !(i == SHADOW_CTR && to_shadow)) begin
        set_dt[i]  = 1'b1;
        set_ex[i]  = f_rtr;
        set_row[i] = data_updated_flag_q[i] && (i != SHADOW_CTR);
      end
    end
    if (to_shadow && sh_full_q) begin
      set_row[SHADOW_CTR] = 1'b1;
    end
    if (move_now) begin
      set_dt[SHADOW_CTR] = 1'b1;
      set_ex[SHADOW_CTR] = sh_frame_q[FRM_RTR_BIT];
    end
  end

  // center configuration, software owned
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      owe_q <= CTR_VEC_RST;
      rxm_q <= CTR_VEC_RST;
    end else if (CFG_WE_I && CFG_IDX_I < IDX_W'(NUM_CTR)) begin
      owe_q[CFG_IDX_I] <= CFG_OWE_I;
      rxm_q[CFG_IDX_I] <= CFG_RX_I;
    end
  end

  // arbitration values have no reset; software programs them in init
  always_ff @(posedge CLK_I) begin
    if (CFG_WE_I && CFG_IDX_I < IDX_W'(NUM_CTR)) begin
      arb_q[CFG_IDX_I] <= CFG_ARB_I;
    end
  end

  // frame contents into a center, direct or from the shadow
  always_ff @(posedge CLK_I) begin
    if (move_now) begin
      dlc_q[SHADOW_CTR]  <= sh_frame_q[FRM_DLC_LSB +: DLC_W];
      data_q[SHADOW_CTR] <= sh_frame_q[FRM_DATA_LSB +: DATA_W];
    end else if (take && !to_shadow) begin
      dlc_q[tgt]  <= buf_if.frame[FRM_DLC_LSB +: DLC_W];
      data_q[tgt] <= buf_if.frame[FRM_DATA_LSB +: DATA_W];
    end
  end

  // shadow buffer of center 15
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      sh_full_q  <= 1'b0;
      sh_frame_q <= '0;
    end else if (to_shadow) begin
      sh_frame_q <= buf_if.frame;
      sh_full_q  <= 1'b1;
    end else if (move_now) begin
      sh_full_q  <= 1'b0;
    end
  end

  // flags: a hardware set in the same cycle as a clear wins
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      data_updated_flag_q  <= CTR_VEC_RST;
      external_request_pending_q <= CTR_VEC_RST;
      row_q   <= CTR_VEC_RST;
    end else begin
      data_updated_flag_q  <= set_dt | (data_updated_flag_q & ~CLR_DATA_UPDATED_FLAG_I);
      external_request_pending_q <= set_ex | (external_request_pending_q & ~CLR_EXTERNAL_REQUEST_PENDING_I);
      row_q   <= set_row | (row_q & ~CLR_ROW_I);
    end
  end

  // lost frame pulse: matched somewhere but nowhere to go
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      lost_q <= 1'b0;
    end else begin
      lost_q <= buf_if.valid && buf_if.ready && !swinit_q && (|hit) && !any_elig;
    end
  end

  // init hold and enable registers under soft reset
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      swinit_q <= SWINIT_RST;
      rx_en_q  <= CTR_VEC_RST;
      tx_en_q  <= CTR_VEC_RST;
    end else if (SOFT_RESET_I) begin
      swinit_q <= 1'b1;
      rx_en_q  <= CTR_VEC_RST;
      tx_en_q  <= CTR_VEC_RST;
    end else begin
      if (SWINIT_CLR_I) begin
        swinit_q <= 1'b0;
      end
      if (EN_WE_I) begin
        rx_en_q <= RX_EN_I;
        tx_en_q <= TX_EN_I;
      end
    end
  end

  // error counters saturate instead of wrapping, so the flag cannot fall back
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I || SOFT_RESET_I) begin
      rec_q  <= ERR_RST;
      tec_q  <= ERR_RST;
      error_count_exceeded_flag_q <= 1'b0;
    end else begin
      if (REC_INC8_I) begin
        rec_q <= (rec_q > ERR_MAX - ERR_STEP_EIGHT) ? ERR_MAX : rec_q + ERR_STEP_EIGHT;
      end else if (REC_INC1_I) begin
        rec_q <= (rec_q == ERR_MAX) ? ERR_MAX : rec_q + ERR_STEP_ONE;
      end
      if (TEC_INC8_I) begin
        tec_q <= (tec_q > ERR_MAX - ERR_STEP_EIGHT) ? ERR_MAX : tec_q + ERR_STEP_EIGHT;
      end
      error_count_exceeded_flag_q <= (rec_q > ERR_LIMIT) || (tec_q > ERR_LIMIT);
    end
  end

  // receive pin synchroniser; first stage feeds only the second
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      rx_s1_q <= TX_IDLE;
      rx_s2_q <= TX_IDLE;
    end else begin
      rx_s1_q <= RX_PIN_I;
      rx_s2_q <= rx_s1_q;
    end
  end

  // autobaud loopback and silenced transmitter; init hold also keeps bus quiet
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      tx_q     <= TX_IDLE;
      rx_int_q <= TX_IDLE;
    end else begin
      tx_q     <= (autobaud || swinit_q) ? TX_IDLE : TX_INT_I;
      rx_int_q <= autobaud ? (rx_s2_q & TX_INT_I) : rx_s2_q;
    end
  end

  // registered read port
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      rd_arb_q  <= '0;
      rd_dlc_q  <= '0;
      rd_data_q <= '0;
    end else if (RD_IDX_I < IDX_W'(NUM_CTR)) begin
      rd_arb_q  <= arb_q[RD_IDX_I];
      rd_dlc_q  <= dlc_q[RD_IDX_I];
      rd_data_q <= data_q[RD_IDX_I];
    end else begin
      rd_arb_q  <= '0;
      rd_dlc_q  <= '0;
      rd_data_q <= '0;
    end
  end

  // outputs straight from flops
  assign FRAME_LOST_O  = lost_q;
  assign RX_EN_O       = rx_en_q;
  assign TX_EN_O       = tx_en_q;
  assign DATA_UPDATED_FLAG_O        = data_updated_flag_q;
  assign EXTERNAL_REQUEST_PENDING_O       = external_request_pending_q;
  assign ROW_O         = row_q;
  assign SHADOW_FULL_O = sh_full_q;
  assign RD_ARB_O      = rd_arb_q;
  assign RD_DLC_O      = rd_dlc_q;
  assign RD_DATA_O     = rd_data_q;
  assign SWINIT_O      = swinit_q;
  assign REC_O         = rec_q;
  assign TEC_O         = tec_q;
  assign ERROR_COUNT_EXCEEDED_FLAG_O        = error_count_exceeded_flag_q;
  assign TX_PIN_O      = tx_q;
  assign RX_INT_O      = rx_int_q;
endmodule // cms_store

/* File: verification/cms_store_props.sv */
`timescale 1ns/1ps
module cms_store_chk
  import cms_pkg::*;
(
  // clock and reset
  input wire logic               CLK_I,
  input wire logic               RESET_N_I,
  // watched inputs
  input wire logic [MCTRL_W-1:0] MODULE_CTRL_I,
  input wire logic               SOFT_RESET_I,
  input wire logic               RX_PIN_I,
  input wire logic               TX_INT_I,
  input wire logic [NUM_CTR-1:0] CLR_ROW_I,
  // watched outputs
  input wire logic               TX_PIN_O,
  input wire logic               RX_INT_O,
  input wire logic               SWINIT_O,
  input wire logic [NUM_CTR-1:0] RX_EN_O,
  input wire logic [ERR_W-1:0]   REC_O,
  input wire logic [ERR_W-1:0]   TEC_O,
  input wire logic               ERROR_COUNT_EXCEEDED_FLAG_O,
  input wire logic               FRAME_LOST_O,
  input wire logic [NUM_CTR-1:0] DATA_UPDATED_FLAG_O,
  input wire logic [NUM_CTR-1:0] EXTERNAL_REQUEST_PENDING_O,
  input wire logic [NUM_CTR-1:0] ROW_O,
  input wire logic               SHADOW_FULL_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_tx_held_high:
    assert property (MODULE_CTRL_I[MCTRL_AUTOBAUD_BIT] |=> TX_PIN_O) else $error("transmit pin not recessive");
  // sync chain needs three clean edges before the relation holds
  a_rx_loopback:
    assert property ($past(RESET_N_I, 3) && $past(RESET_N_I, 2) && $past(RESET_N_I)
      && $past(MODULE_CTRL_I[MCTRL_AUTOBAUD_BIT])
      |-> RX_INT_O == ($past(RX_PIN_I, 3) & $past(TX_INT_I))) else $error("loopback receive bit wrong");
  a_soft_rst_clear:
    assert property (SOFT_RESET_I |=> SWINIT_O && RX_EN_O == CTR_VEC_RST && REC_O == ERR_RST && !ERROR_COUNT_EXCEEDED_FLAG_O)
      else $error("soft reset left state behind");
  a_error_count_exceeded_flag_thresh:
    assert property ($past(RESET_N_I) && !$past(SOFT_RESET_I)
      |-> ERROR_COUNT_EXCEEDED_FLAG_O == ($past(REC_O) > ERR_LIMIT || $past(TEC_O) > ERR_LIMIT))
      else $error("exceeded flag disagrees with counters");
  a_drop_no_row:
    assert property (FRAME_LOST_O && !$past(|CLR_ROW_I) |-> $stable(ROW_O)) else $error("drop touched overwrite flags");
  a_row_needs_data_updated_flag:
    assert property ($rose(ROW_O[0]) |-> DATA_UPDATED_FLAG_O[0] && $past(DATA_UPDATED_FLAG_O[0])) else $error("overwrite flag without unread data");
  a_row15_shadow:
    assert property ($rose(ROW_O[SHADOW_CTR]) |-> $past(SHADOW_FULL_O)) else $error("center 15 overwrite with empty shadow");
  a_shadow_move:
    assert property (SHADOW_FULL_O && !DATA_UPDATED_FLAG_O[SHADOW_CTR] && !EXTERNAL_REQUEST_PENDING_O[SHADOW_CTR] |=> DATA_UPDATED_FLAG_O[SHADOW_CTR] && !SHADOW_FULL_O)
      else $error("shadow not moved into center 15");

  c_drop: cover property (FRAME_LOST_O);
  c_row15: cover property ($rose(ROW_O[SHADOW_CTR]));
  c_move: cover property ($fell(SHADOW_FULL_O));
endmodule // cms_store_chk

bind cms_store cms_store_chk chk_u (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .MODULE_CTRL_I(MODULE_CTRL_I),
  .SOFT_RESET_I(SOFT_RESET_I), .RX_PIN_I(RX_PIN_I), .TX_INT_I(TX_INT_I), .CLR_ROW_I(CLR_ROW_I),
  .TX_PIN_O(TX_PIN_O), .RX_INT_O(RX_INT_O), .SWINIT_O(SWINIT_O), .RX_EN_O(RX_EN_O), .REC_O(REC_O),
  .TEC_O(TEC_O), .ERROR_COUNT_EXCEEDED_FLAG_O(ERROR_COUNT_EXCEEDED_FLAG_O), .FRAME_LOST_O(FRAME_LOST_O), .DATA_UPDATED_FLAG_O(DATA_UPDATED_FLAG_O), .EXTERNAL_REQUEST_PENDING_O(EXTERNAL_REQUEST_PENDING_O),
  .ROW_O(ROW_O), .SHADOW_FULL_O(SHADOW_FULL_O));

/* File: verification/cms_bus_model.sv */
`timescale 1ns/1ps
module cms_bus_model (
  // node drives
  input  wire logic tx_pin_i,
  input  wire logic node_level_i,
  // line seen by the block
  output logic      rx_pin_o
);
  // dominant low wins, so the line is the AND of every node; idle is recessive high
  assign rx_pin_o = tx_pin_i & node_level_i;
endmodule // cms_bus_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import cms_pkg::*;
  logic               CLK_I, RESET_N_I, FRAME_VALID_I, CFG_WE_I, CFG_OWE_I, EN_WE_I, SOFT_RESET_I;
  logic               SWINIT_CLR_I, REC_INC8_I, TEC_INC8_I, TX_INT_I, node_level, RX_PIN_I;
  logic [FRAME_W-1:0] FRAME_I;
  logic [IDX_W-1:0]   CFG_IDX_I, RD_IDX_I;
  logic [ID_W-1:0]    CFG_ARB_I, RD_ARB_O;
  logic [NUM_CTR-1:0] RX_EN_I, CLR_DATA_UPDATED_FLAG_I, RX_EN_O, TX_EN_O, DATA_UPDATED_FLAG_O, EXTERNAL_REQUEST_PENDING_O, ROW_O;
  logic [MCTRL_W-1:0] MODULE_CTRL_I;
  logic [DLC_W-1:0]   RD_DLC_O;
  logic [DATA_W-1:0]  RD_DATA_O;
  logic [ERR_W-1:0]   REC_O, TEC_O;
  logic               FRAME_READY_O, FRAME_LOST_O, SHADOW_FULL_O, SWINIT_O, ERROR_COUNT_EXCEEDED_FLAG_O, TX_PIN_O, RX_INT_O;
  int                 mismatches, checks, lost;
  localparam logic [ID_W-1:0] ARB_A = 29'h0000123, ARB_B = 29'h1abc000, ARB_C = 29'h0055aa5;

  cms_store dut_u (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .FRAME_VALID_I(FRAME_VALID_I), .FRAME_I(FRAME_I),
    .FRAME_READY_O(FRAME_READY_O), .FRAME_LOST_O(FRAME_LOST_O), .CFG_WE_I(CFG_WE_I), .CFG_IDX_I(CFG_IDX_I),
    .CFG_ARB_I(CFG_ARB_I), .CFG_OWE_I(CFG_OWE_I), .CFG_RX_I(1'b1), .EN_WE_I(EN_WE_I), .RX_EN_I(RX_EN_I),
    .TX_EN_I(RX_EN_I), .RX_EN_O(RX_EN_O), .TX_EN_O(TX_EN_O), .CLR_DATA_UPDATED_FLAG_I(CLR_DATA_UPDATED_FLAG_I), .CLR_EXTERNAL_REQUEST_PENDING_I(CLR_DATA_UPDATED_FLAG_I),
    .CLR_ROW_I(CLR_DATA_UPDATED_FLAG_I), .DATA_UPDATED_FLAG_O(DATA_UPDATED_FLAG_O), .EXTERNAL_REQUEST_PENDING_O(EXTERNAL_REQUEST_PENDING_O), .ROW_O(ROW_O), .SHADOW_FULL_O(SHADOW_FULL_O),
    .RD_IDX_I(RD_IDX_I), .RD_ARB_O(RD_ARB_O), .RD_DLC_O(RD_DLC_O), .RD_DATA_O(RD_DATA_O),
    .MODULE_CTRL_I(MODULE_CTRL_I), .SOFT_RESET_I(SOFT_RESET_I), .SWINIT_CLR_I(SWINIT_CLR_I), .SWINIT_O(SWINIT_O),
    .REC_INC1_I(1'b0), .REC_INC8_I(REC_INC8_I), .TEC_INC8_I(TEC_INC8_I), .REC_O(REC_O), .TEC_O(TEC_O),
    .ERROR_COUNT_EXCEEDED_FLAG_O(ERROR_COUNT_EXCEEDED_FLAG_O), .RX_PIN_I(RX_PIN_I), .TX_INT_I(TX_INT_I), .TX_PIN_O(TX_PIN_O), .RX_INT_O(RX_INT_O));
  cms_bus_model bus_u (.tx_pin_i(TX_PIN_O), .node_level_i(node_level), .rx_pin_o(RX_PIN_I));

  initial begin
    CLK_I = 1'b0;
    forever #2.5 CLK_I = ~CLK_I;
  end
  // dropped frames leave only a one-cycle pulse, so count them as they pass
  always @(posedge CLK_I) if (FRAME_LOST_O === 1'b1) lost++;

  task automatic summarize();
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge CLK_I);
    @(negedge CLK_I);
  endtask
  task automatic chk_flags(input logic [NUM_CTR-1:0] got, input logic [NUM_CTR-1:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: flags %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_data({63'h0, got}, {63'h0, exp});
  endtask
  task automatic cfg(input logic [IDX_W-1:0] idx, input logic [ID_W-1:0] arb, input logic owe);
    @(posedge CLK_I);
    CFG_WE_I <= 1'b1;
    CFG_IDX_I <= idx;
    CFG_ARB_I <= arb;
    CFG_OWE_I <= owe;
    @(posedge CLK_I);
    CFG_WE_I <= 1'b0;
  endtask
  // hold the frame until the buffer shows room at a sampling edge
  task automatic send(input logic [ID_W-1:0] id, input logic [DATA_W-1:0] d, input logic rtr = 1'b0);
    @(posedge CLK_I);
    FRAME_VALID_I <= 1'b1;
    FRAME_I <= {rtr, 4'h8, id, d};
    @(negedge CLK_I);
    while (FRAME_READY_O !== 1'b1) @(negedge CLK_I);
    @(posedge CLK_I);
    FRAME_VALID_I <= 1'b0;
    step(4);
  endtask
  task automatic clr(input logic [NUM_CTR-1:0] m);
    @(posedge CLK_I);
    CLR_DATA_UPDATED_FLAG_I <= m;
    @(posedge CLK_I);
    CLR_DATA_UPDATED_FLAG_I <= '0;
    step(3);
  endtask
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] exp);
    @(posedge CLK_I);
    RD_IDX_I <= idx;
    step(2);
    chk_data(RD_DATA_O, exp);
    chk_data(64'(RD_DLC_O), 64'h8);
  endtask
  task automatic err_pulse();
    @(posedge CLK_I);
    REC_INC8_I <= 1'b1;
    TEC_INC8_I <= 1'b1;
    @(posedge CLK_I);
    REC_INC8_I <= 1'b0;
    TEC_INC8_I <= 1'b0;
  endtask

  initial begin
    {FRAME_VALID_I, CFG_WE_I, CFG_OWE_I, EN_WE_I, SOFT_RESET_I, SWINIT_CLR_I, REC_INC8_I, TEC_INC8_I, TX_INT_I} = '0;
    {FRAME_I, CFG_IDX_I, RD_IDX_I, CFG_ARB_I, RX_EN_I, CLR_DATA_UPDATED_FLAG_I, MODULE_CTRL_I} = '0;
    RESET_N_I = 1'b0;
    node_level = 1'b1;
    repeat (5) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    @(posedge CLK_I);
    SWINIT_CLR_I <= 1'b1;
    EN_WE_I <= 1'b1;
    RX_EN_I <= '1;
    @(posedge CLK_I);
    SWINIT_CLR_I <= 1'b0;
    EN_WE_I <= 1'b0;
    // overwrite on: the lower center keeps taking every frame
    cfg(4'h0, ARB_A, 1'b1);
    cfg(4'h1, ARB_A, 1'b1);
    send(ARB_A, 64'h1111);
    chk_flags(ROW_O, 15'h0000);
    send(ARB_A, 64'h2222);
    chk_flags(ROW_O, 15'h0001);
    send(ARB_A, 64'h3333);
    chk_flags(DATA_UPDATED_FLAG_O, 15'h0001);
    rd(4'h0, 64'h3333);
    send(ARB_A, 64'h4444, 1'b1);
    chk_flags(EXTERNAL_REQUEST_PENDING_O, 15'h0001);
    clr(15'h0001);
    chk_flags(EXTERNAL_REQUEST_PENDING_O, 15'h0000);
    // overwrite off: spill to the next center, then drop with a lost pulse and no overwrite flag
    cfg(4'h2, ARB_B, 1'b0);
    cfg(4'h3, ARB_B, 1'b0);
    send(ARB_B, 64'ha1);
    send(ARB_B, 64'ha2);
    chk_flags(DATA_UPDATED_FLAG_O, 15'h000c);
    send(ARB_B, 64'ha3);
    chk_data(64'(lost), 64'h1);
    chk_flags(ROW_O, 15'h0000);
    rd(4'h3, 64'ha2);
    clr(15'h0004);
    send(ARB_B, 64'ha4);
    rd(4'h2, 64'ha4);
    clr(15'h000c);
    // center 15 with its shadow, overwrite off
    cfg(4'he, ARB_C, 1'b0);
    send(ARB_C, 64'hc1);
    chk_bit(SHADOW_FULL_O, 1'b0);
    send(ARB_C, 64'hc2);
    chk_bit(SHADOW_FULL_O, 1'b1);
    send(ARB_C, 64'hc3);
    chk_data(64'(lost), 64'h2);
    rd(4'he, 64'hc1);
    clr(15'h4000);
    chk_flags(DATA_UPDATED_FLAG_O, 15'h4000);
    rd(4'he, 64'hc2);
    // overwrite on: shadow replaced, flag only when shadow was unread
    cfg(4'he, ARB_C, 1'b1);
    send(ARB_C, 64'hc4);
    chk_flags(ROW_O, 15'h0000);
    send(ARB_C, 64'hc5);
    chk_flags(ROW_O, 15'h4000);
    rd(4'he, 64'hc2);
    clr(15'h4000);
    rd(4'he, 64'hc5);
    chk_data(64'(RD_ARB_O), 64'(ARB_C));
    // autobaud listening
    step(0);
    chk_bit(TX_PIN_O, 1'b0);
    @(posedge CLK_I);
    MODULE_CTRL_I <= 8'h04;
    step(2);
    chk_bit(TX_PIN_O, 1'b1);
    @(posedge CLK_I);
    TX_INT_I <= 1'b1;
    step(4);
    chk_bit(RX_INT_O, 1'b1);
    @(posedge CLK_I);
    node_level <= 1'b0;
    step(4);
    chk_bit(RX_INT_O, 1'b0);
    @(posedge CLK_I);
    node_level <= 1'b1;
    TX_INT_I <= 1'b0;
    step(4);
    chk_bit(RX_INT_O, 1'b0);
    repeat (16) err_pulse();
    step(2);
    chk_data(64'(REC_O), 64'(ERR_LIMIT));
    chk_data(64'(TEC_O), 64'(ERR_LIMIT));
    chk_bit(ERROR_COUNT_EXCEEDED_FLAG_O, 1'b0);
    err_pulse();
    step(2);
    chk_bit(ERROR_COUNT_EXCEEDED_FLAG_O, 1'b1);
    @(posedge CLK_I);
    SOFT_RESET_I <= 1'b1;
    @(posedge CLK_I);
    SOFT_RESET_I <= 1'b0;
    step(1);
    chk_bit(SWINIT_O, 1'b1);
    chk_flags(RX_EN_O, CTR_VEC_RST);
    chk_data(64'(REC_O), 64'h0);
    chk_data(64'(TEC_O), 64'h0);
    chk_flags(TX_EN_O, CTR_VEC_RST);
    @(posedge CLK_I);
    SWINIT_CLR_I <= 1'b1;
    @(posedge CLK_I);
    SWINIT_CLR_I <= 1'b0;
    step(1);
    chk_bit(SWINIT_O, 1'b0);
    summarize();
  end
  // a healthy run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge CLK_I);
    mismatches++;
    summarize();
  end
endmodule // tb_top
